// File: logic/pivc_pkg.sv
// Shared constants for the prioritized interrupt vector controller
// ==========================================
package pivc_pkg;
	localparam int num_levels = 8;
	localparam logic [3:0] block_select_reset = 4'hE;
	localparam logic [3:0] vector_upper_reset = 4'hF;
	localparam logic [1:0] trig_low = 2'h0;
	localparam logic [1:0] trig_high = 2'h1;
	localparam logic [1:0] trig_rise = 2'h2;
	localparam logic [1:0] trig_fall = 2'h3;
	localparam logic [1:0] mode_vectored = 2'h0;
	localparam logic [1:0] mode_fixed = 2'h1;
	localparam logic [1:0] mode_legacy = 2'h2;
	localparam logic [1:0] mode_lines = 2'h3;
	localparam logic [7:0] restart_base = 8'hC7;
	localparam int timebase_ns = 1000;
	localparam int clk_period_ns = 10;
	localparam int timebase_cycles = timebase_ns / clk_period_ns;
	localparam int num_rates = 5;
	localparam int decade = 10;
endpackage : pivc_pkg

// File: logic/decade_tick.sv
// Decade divider chain producing the periodic tick
module decade_tick #(
	parameter int timebase_cycles = pivc_pkg::timebase_cycles
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [2:0] periodic_tick_select,
	output logic tick_out,
	output logic tick_oe
);
	// ==========================================
	// Base 1 us enable
	logic [15:0] pre;
	logic [15:0] next_pre;
	logic base_en;
	always_comb begin
		base_en = (pre == 16'(timebase_cycles - 1));
		next_pre = base_en ? 16'h0000 : pre + 16'h0001;
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pre <= 16'h0000;
		end else begin
			pre <= next_pre;
		end
	end
	// ==========================================
	// Decade stages; rate 0 is the base period itself
	logic [3:0] cnt [pivc_pkg::num_rates - 1];
	logic [3:0] next_cnt [pivc_pkg::num_rates - 1];
	logic en [pivc_pkg::num_rates];
	logic [pivc_pkg::num_rates - 1:0] sq;
	assign en[0] = base_en;
	assign sq[0] = (pre < 16'(timebase_cycles / 2));
	genvar g;
	generate
		for (g = 0; g < pivc_pkg::num_rates - 1; g++) begin : stage
			assign en[g + 1] = en[g] && (cnt[g] == 4'(pivc_pkg::decade - 1));
			assign sq[g + 1] = (cnt[g] < 4'(pivc_pkg::decade / 2));
			always_comb begin
				next_cnt[g] = cnt[g];
				if (en[g]) begin
					next_cnt[g] = en[g + 1] ? 4'h0 : cnt[g] + 4'h1;
				end
			end
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					cnt[g] <= 4'h0;
				end else begin
					cnt[g] <= next_cnt[g];
				end
			end
		end
	endgenerate
	// ==========================================
	// Open-collector output: drive low only
	logic next_oe;
	always_comb begin
		next_oe = 1'b0;
		if (periodic_tick_select < 3'(pivc_pkg::num_rates)) begin
			next_oe = !sq[periodic_tick_select];
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tick_oe <= 1'b0;
		end else begin
			tick_oe <= next_oe;
		end
	end
	assign tick_out = 1'b0;
endmodule : decade_tick

// File: logic/pivc.sv
// Prioritized interrupt vector controller top
module prioritized_interrupt_vector_controller #(
	parameter int num_levels = pivc_pkg::num_levels
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] io_addr,
	input wire logic io_rd,
	input wire logic io_wr,
	input wire logic [3:0] block_select,
	input wire logic block_select_valid,
	output logic port_hit,
	output logic [3:0] port_index,
	input wire logic [7:0] irq_in,
	input wire logic [15:0] trigger_select,
	input wire logic [7:0] level_mask,
	input wire logic [1:0] int_mode,
	input wire logic [3:0] vector_upper,
	input wire logic vector_upper_valid,
	input wire logic int_ack,
	output logic int_req,
	output logic [7:0] ack_data,
	output logic ack_data_oe,
	output logic [7:0] level_lines,
	output logic [7:0] pending,
	input wire logic [2:0] periodic_tick_select,
	output logic tick_out,
	output logic tick_oe
);
	// ==========================================
	// Configuration latches
	logic [3:0] blk;
	logic [3:0] next_blk;
	logic [3:0] vup;
	logic [3:0] next_vup;
	always_comb begin
		next_blk = block_select_valid ? block_select : blk;
		next_vup = vector_upper_valid ? vector_upper : vup;
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			blk <= pivc_pkg::block_select_reset;
			vup <= pivc_pkg::vector_upper_reset;
		end else begin
			blk <= next_blk;
			vup <= next_vup;
		end
	end
	// ==========================================
	// Port decode
	logic next_hit;
	logic [3:0] next_idx;
	always_comb begin
		next_hit = (io_rd || io_wr) && (io_addr[7:4] == blk);
		next_idx = io_addr[3:0];
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			port_hit <= 1'b0;
			port_index <= 4'h0;
		end else begin
			port_hit <= next_hit;
			port_index <= next_idx;
		end
	end
	// ==========================================
	// Input synchronisers, three stages
	logic [7:0] s1;
	logic [7:0] s2;
	logic [7:0] s3;
	logic [7:0] lvl;
	logic [7:0] next_lvl;
	always_comb begin
		next_lvl = (s2 == s3) ? s3 : lvl;
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s1 <= 8'h00;
			s2 <= 8'h00;
			s3 <= 8'h00;
			lvl <= 8'h00;
		end else begin
			s1 <= irq_in;
			s2 <= s1;
			s3 <= s2;
			lvl <= next_lvl;
		end
	end
	// ==========================================
	// Trigger, priority and acknowledge
	function automatic logic [2:0] top_level(input logic [7:0] req);
		logic [2:0] r;
		r = 3'h0;
		for (int i = num_levels - 1; i >= 0; i--) begin
			if (req[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction : top_level
	logic [7:0] lvl_d;
	logic [7:0] edge_pend;
	logic [7:0] next_edge_pend;
	logic [7:0] req;
	logic ack_d;
	logic ack_start;
	logic [2:0] grant;
	logic [7:0] next_ack_data;
	logic [7:0] next_lines;
	logic next_oe;
	always_comb begin
		ack_start = int_ack && !ack_d;
		next_edge_pend = edge_pend;
		req = 8'h00;
		for (int i = 0; i < num_levels; i++) begin
			case (trigger_select[2*i +: 2])
				pivc_pkg::trig_low: req[i] = !lvl[i];
				pivc_pkg::trig_high: req[i] = lvl[i];
				pivc_pkg::trig_rise: begin
					if (lvl[i] && !lvl_d[i]) begin
						next_edge_pend[i] = 1'b1;
					end
					req[i] = edge_pend[i];
				end
				pivc_pkg::trig_fall: begin
					if (!lvl[i] && lvl_d[i]) begin
						next_edge_pend[i] = 1'b1;
					end
					req[i] = edge_pend[i];
				end
				default: req[i] = 1'b0;
			endcase
		end
		req = req & level_mask;
		grant = top_level(req);
		if (ack_start && trigger_select[2*grant + 1] && req[grant]) begin
			// New edge in same cycle still wins
			if (!((trigger_select[2*grant +: 2] == pivc_pkg::trig_rise) && lvl[grant]
					&& !lvl_d[grant])
				&& !((trigger_select[2*grant +: 2] == pivc_pkg::trig_fall) && !lvl[grant]
					&& lvl_d[grant])) begin
				next_edge_pend[grant] = 1'b0;
			end
		end
		for (int i = 0; i < num_levels; i++) begin
			if (trigger_select[2*i + 1] == 1'b0) begin
				next_edge_pend[i] = 1'b0;
			end
		end
		next_ack_data = ack_data;
		next_oe = ack_data_oe && int_ack;
		if (ack_start && (req != 8'h00)) begin
			case (int_mode)
				pivc_pkg::mode_vectored: begin
					next_ack_data = {vup, grant, 1'b0};
					next_oe = 1'b1;
				end
				pivc_pkg::mode_legacy: begin
					next_ack_data = pivc_pkg::restart_base | {2'h0, grant, 3'h0};
					next_oe = 1'b1;
				end
				default: next_oe = 1'b0;
			endcase
		end
		next_lines = 8'h00;
		if ((int_mode == pivc_pkg::mode_lines) && (req != 8'h00)) begin
			next_lines = 8'h01 << grant;
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lvl_d <= 8'h00;
			edge_pend <= 8'h00;
			ack_d <= 1'b0;
			ack_data <= 8'h00;
			ack_data_oe <= 1'b0;
			level_lines <= 8'h00;
			pending <= 8'h00;
			int_req <= 1'b0;
		end else begin
			lvl_d <= lvl;
			edge_pend <= next_edge_pend;
			ack_d <= int_ack;
			ack_data <= next_ack_data;
			ack_data_oe <= next_oe;
			level_lines <= next_lines;
			pending <= req;
			int_req <= (req != 8'h00) && (int_mode != pivc_pkg::mode_lines);
		end
	end
	// ==========================================
	// Periodic tick
	decade_tick #(
		.timebase_cycles(pivc_pkg::timebase_cycles)
	) u_tick (
		.sys_clk(sys_clk),
		.rst(rst),
		.periodic_tick_select(periodic_tick_select),
		.tick_out(tick_out),
		.tick_oe(tick_oe)
	);
endmodule : prioritized_interrupt_vector_controller

// File: tb/pivc_props.sv
// Port assertions for the interrupt controller
module pivc_props (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] io_addr,
	input wire logic io_rd,
	input wire logic io_wr,
	input wire logic port_hit,
	input wire logic [3:0] port_index,
	input wire logic [7:0] pending,
	input wire logic [1:0] int_mode,
	input wire logic int_ack,
	input wire logic [7:0] ack_data,
	input wire logic ack_data_oe,
	input wire logic [7:0] level_lines,
	input wire logic tick_out,
	input wire logic tick_oe,
	input wire logic [2:0] periodic_tick_select,
	input wire logic [3:0] block_select,
	input wire logic block_select_valid
);
timeunit 1ns;
timeprecision 1ns;
// ==========
// Block value as the host last loaded it
logic [3:0] blk_model;
always_ff @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		blk_model <= pivc_pkg::block_select_reset;
	end else if (block_select_valid) begin
		blk_model <= block_select;
	end
end
// ==========
// Checks
default clocking @(posedge sys_clk); endclocking
default disable iff (rst);
sequence ack_start;
	$rose(int_ack);
endsequence
sequence vec_out;
	$rose(ack_data_oe) && int_mode == 2'h0;
endsequence
AST_HIT: assert property (port_hit |-> $past(io_rd | io_wr) && $past(io_addr[3:0]) == port_index)
	else $error("bad decode");
AST_OFF: assert property ((io_rd | io_wr) && io_addr[7:4] != blk_model |=> !port_hit)
	else $error("bad block");
AST_ON: assert property ((io_rd | io_wr) && io_addr[7:4] == blk_model |=> port_hit)
	else $error("missed block");
AST_EVEN: assert property (vec_out |-> !ack_data[0])
	else $error("odd vector");
AST_PRIO: assert property (vec_out |-> pending[ack_data[3:1]]
	&& (pending & ((8'h01 << ack_data[3:1]) - 8'h01)) == 8'h00)
	else $error("bad priority");
AST_LEG: assert property (ack_data_oe && int_mode == 2'h2 |-> ack_data[7:6] == 2'h3 && ack_data[2:0] == 3'h7)
	else $error("bad restart");
AST_MODE: assert property (ack_data_oe |-> int_mode == 2'h0 || int_mode == 2'h2)
	else $error("data in wrong mode");
AST_GO: assert property (ack_start and (|pending && int_mode == 2'h0) |=> ack_data_oe)
	else $error("no answer");
AST_NONE: assert property (ack_start and pending == 8'h00 |=> !ack_data_oe)
	else $error("empty answer");
AST_DROP: assert property (ack_data_oe && !int_ack |=> !ack_data_oe)
	else $error("data held");
AST_LINES: assert property (level_lines != 8'h00 |-> $onehot(level_lines) && $past(int_mode) == 2'h3)
	else $error("bad lines");
AST_TICK: assert property (!tick_out)
	else $error("tick driven high");
AST_TICK_OFF: assert property (periodic_tick_select >= 3'(pivc_pkg::num_rates) |=> !tick_oe)
	else $error("tick in off setting");
endmodule : pivc_props
bind prioritized_interrupt_vector_controller pivc_props chk (.sys_clk, .rst, .io_addr, .io_rd,
	.io_wr, .port_hit, .port_index, .pending, .int_mode, .int_ack, .ack_data, .ack_data_oe,
	.level_lines, .tick_out, .tick_oe, .periodic_tick_select, .block_select, .block_select_valid);

// File: tb/host_cpu_model.sv
// Host processor model running acknowledge cycles
module host_cpu_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ack_go,
	input wire logic ack_data_oe,
	input wire logic [7:0] ack_data,
	output logic int_ack,
	output logic [7:0] vec
);
timeunit 1ns;
timeprecision 1ns;
// ==========
// Acknowledge cycle
logic [1:0] n;
always_ff @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		int_ack <= 1'b0;
		n <= 2'h0;
		vec <= 8'h00;
	end else if (ack_go && n == 2'h0) begin
		int_ack <= 1'b1;
		n <= 2'h3;
		vec <= 8'h00;
	end else if (n != 2'h0) begin
		n <= n - 2'h1;
		int_ack <= n != 2'h1;
		if (int_ack && ack_data_oe) vec <= ack_data;
	end
end
endmodule : host_cpu_model

// File: tb/prioritized_interrupt_vector_controller_bench.sv
// Bench for the interrupt controller
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
	$display("Error %0t mismatch", $time); end end
module prioritized_interrupt_vector_controller_bench;
timeunit 1ns;
timeprecision 1ns;
typedef struct packed {logic [15:0] t; logic [7:0] i; logic [1:0] m; logic [7:0] e;} row_type;
logic sys_clk = 0, rst = 1, io_rd = 0, io_wr = 0, block_select_valid = 0;
logic vector_upper_valid = 0, ack_go = 0, port_hit, int_req, ack_data_oe, tick_out, tick_oe;
logic int_ack;
logic [7:0] io_addr = 0, irq_in = 0, level_mask = 8'hFF, ack_data, level_lines, pending, vec;
logic [15:0] trigger_select = 16'h5555;
logic [1:0] int_mode = 0;
logic [3:0] block_select = 4'hE, vector_upper = 4'hF, port_index;
logic [2:0] periodic_tick_select = 0;
int mismatches = 0, n_checks = 0, tick_count = 0;
row_type rows [6] = '{'{16'h5555, 8'h04, 2'h0, 8'hF4}, '{16'h5555, 8'h84, 2'h0, 8'hF4},
	'{16'h5555, 8'h81, 2'h0, 8'hF0}, '{16'h5555, 8'h80, 2'h0, 8'hFE},
	'{16'h5555, 8'h08, 2'h2, 8'hDF}, '{16'h5155, 8'h00, 2'h0, 8'hFA}};
prioritized_interrupt_vector_controller uut (.*);
host_cpu_model cpu (.*);
always #5 sys_clk = ~sys_clk;
task end_sim;
	$display("%0d checks, %0d errors", n_checks, mismatches);
	if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
	else $display("[ FAIL ]");
	$finish;
endtask : end_sim
task do_ack;
	@(posedge sys_clk);
	ack_go <= 1'b1;
	@(posedge sys_clk);
	ack_go <= 1'b0;
	repeat (6) @(posedge sys_clk);
	#1;
endtask : do_ack
task settle(input logic [7:0] i);
	@(posedge sys_clk);
	irq_in <= i;
	repeat (8) @(posedge sys_clk);
endtask : settle
task count_tick(input logic [2:0] s, input int span, output int c);
	@(posedge sys_clk);
	periodic_tick_select <= s;
	repeat (2) @(posedge sys_clk);
	c = 0;
	repeat (span) begin
		@(posedge sys_clk);
		#1;
		if (tick_oe === 1'b1) c++;
		else if (tick_oe !== 1'b0) c += 1000;
	end
endtask : count_tick
initial begin
	repeat (4000) @(posedge sys_clk);
	mismatches++;
	end_sim();
end
initial begin
	repeat (20) @(posedge sys_clk);
	rst <= 1'b0;
	io_addr <= 8'hE5;
	io_rd <= 1'b1;
	@(posedge sys_clk);
	io_rd <= 1'b0;
	#1;
	`CHK({port_hit, port_index}, 5'h15);
	@(posedge sys_clk);
	io_addr <= 8'h75;
	io_rd <= 1'b1;
	@(posedge sys_clk);
	io_rd <= 1'b0;
	#1;
	`CHK(port_hit, 1'b0);
	for (int k = 0; k < 6; k++) begin
		@(posedge sys_clk);
		trigger_select <= rows[k].t;
		int_mode <= rows[k].m;
		settle(rows[k].i);
		do_ack();
		`CHK(vec, rows[k].e);
	end
	@(posedge sys_clk);
	trigger_select <= 16'h5795;
	settle(8'h00);
	settle(8'h18);
	do_ack();
	`CHK(vec, 8'hF6);
	`CHK({int_req, pending}, 9'h000);
	settle(8'h00);
	do_ack();
	`CHK(vec, 8'hF8);
	@(posedge sys_clk);
	trigger_select <= 16'h5555;
	settle(8'h02);
	do_ack();
	do_ack();
	`CHK(vec, 8'hF2);
	@(posedge sys_clk);
	vector_upper <= 4'h3;
	vector_upper_valid <= 1'b1;
	@(posedge sys_clk);
	vector_upper_valid <= 1'b0;
	do_ack();
	`CHK(vec, 8'h32);
	@(posedge sys_clk);
	int_mode <= 2'h1;
	do_ack();
	`CHK(vec, 8'h00);
	@(posedge sys_clk);
	int_mode <= 2'h3;
	settle(8'h02);
	#1;
	`CHK({int_req, level_lines}, 9'h002);
	@(posedge sys_clk);
	int_mode <= 2'h0;
	level_mask <= 8'hFD;
	settle(8'h82);
	do_ack();
	`CHK(vec, 8'h3E);
	@(posedge sys_clk);
	level_mask <= 8'hFF;
	settle(8'h00);
	do_ack();
	`CHK(vec, 8'h00);
	@(posedge sys_clk);
	block_select <= 4'h7;
	block_select_valid <= 1'b1;
	@(posedge sys_clk);
	block_select_valid <= 1'b0;
	io_addr <= 8'h75;
	io_wr <= 1'b1;
	@(posedge sys_clk);
	io_wr <= 1'b0;
	#1;
	`CHK({port_hit, port_index}, 5'h15);
	settle(8'h02);
	@(posedge sys_clk);
	rst <= 1'b1;
	@(posedge sys_clk);
	#1;
	`CHK({int_req, pending, ack_data_oe, level_lines, port_hit, tick_oe}, 20'h00000);
	@(posedge sys_clk);
	rst <= 1'b0;
	io_addr <= 8'hE3;
	io_rd <= 1'b1;
	@(posedge sys_clk);
	io_rd <= 1'b0;
	#1;
	`CHK({port_hit, port_index}, 5'h13);
	settle(8'h02);
	do_ack();
	`CHK(vec, 8'hF2);
	count_tick(3'h0, 100, tick_count);
	`CHK(tick_count, 50);
	count_tick(3'h1, 1000, tick_count);
	`CHK(tick_count, 500);
	count_tick(3'h5, 100, tick_count);
	`CHK(tick_count, 0);
	`CHK(tick_out, 1'b0);
	end_sim();
end
endmodule : prioritized_interrupt_vector_controller_bench
